/* File: hw/stop_seq_pkg.sv */
/*
  Package for the drive stop and brake sequencer: register offsets,
  field positions, reset values, encodings and timing counts.
  Assumes a 40 MHz system clock and an APB register bus.
*/
package stop_seq_pkg;
   // Clock
   localparam int CLOCK_HZ = 40_000_000;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFFS = 8'h00;
   localparam logic [7:0] CONFIG_OFFS = 8'h04;
   localparam logic [7:0] VTHRESH_OFFS = 8'h08;
   localparam logic [7:0] TIMEOUT_OFFS = 8'h0C;
   localparam logic [7:0] STATUS_OFFS = 8'h10;
   localparam logic [7:0] FAULT_OFFS = 8'h14;
   // Control register bits
   localparam int CTRL_SOFTWARE_ENABLE = 0;
   localparam int CTRL_FAULT_CLEAR = 1;
   // Configuration register fields
   localparam int CFG_DISMODE_LSB = 0;
   localparam int CFG_BRAKEIMM = 2;
   localparam int CFG_UVMODE = 3;
   localparam int CFG_FCLASS_LSB = 4;
   // Modes and classes
   localparam logic [1:0] DISMODE_IMMEDIATE = 2'h0;
   localparam logic [1:0] DISMODE_CONTROLLED = 2'h2;
   localparam logic [1:0] FCLASS_DISABLE = 2'h0;
   localparam logic [1:0] FCLASS_DYNBRAKE = 2'h1;
   localparam logic [1:0] FCLASS_CONTROLLED = 2'h2;
   // Reset values: immediate disable, undervoltage mode 1
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0008;
   localparam logic [15:0] VTHRESH_RESET = 16'h0064;
   // Stop timeout default, in milliseconds, and its cycle count
   localparam int STOP_TIMEOUT_MS = 100;
   localparam logic [31:0] STOP_TIMEOUT_CYCLES = 32'(CLOCK_HZ / 1000 * STOP_TIMEOUT_MS);
   // Fault and warning bits
   localparam int FLT_UNDERVOLT = 0;
   localparam int FLT_TORQUE_OFF = 1;
   localparam int FLT_EXTERNAL = 2;
   localparam int WRN_UNDERVOLT = 3;
   // Codes reported alongside (arbitrary values)
   localparam logic [7:0] UNDERVOLTAGE_FAULT_CODE = 8'h11;
   localparam logic [7:0] UNDERVOLTAGE_WARNING_CODE = 8'h12;
   localparam logic [7:0] TORQUE_OFF_FAULT_CODE = 8'h21;
endpackage : stop_seq_pkg

/* File: hw/stop_timer.sv */
/*
  Stop completion detector: counts cycles while a stop procedure runs
  and flags completion on velocity below threshold or on timeout.
  Assumes velocity magnitude is sampled every cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module stop_timer #(
   parameter int VEL_W = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Control
   input wire logic running,
   input wire logic [VEL_W-1:0] velocity,
   input wire logic [VEL_W-1:0] threshold,
   input wire logic [31:0] timeout_cycles,
   // Result
   output logic done
);
   typedef struct packed {
      logic [31:0] count; // Cycles spent in this stop
      logic done;         // Completion flag
   } state_t;
   state_t cur_ff, nxt_ff;

   // Compare every cycle, clear the count whenever no stop runs
   always_comb begin
      nxt_ff = cur_ff;
      if (!running) begin
         nxt_ff.count = 32'h0000_0000;
         nxt_ff.done = 1'b0;
      end else begin
         nxt_ff.count = cur_ff.count + 32'h0000_0001;
         // Whichever comes first ends the stop
         if (velocity < threshold || cur_ff.count >= timeout_cycles) begin
            nxt_ff.done = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   assign done = cur_ff.done;
endmodule // stop_timer
`default_nettype wire

/* File: hw/stop_brake_seq.sv */
/*
  Drive stop and holding brake sequencer with an APB register file.
  Assumes synchronous inputs, 40 MHz clock, and velocity magnitude input.
*/
// Operation
// - Drive inactive always engages holding brake
// - Brake on low velocity or timeout
// - Brake-immediate brakes at once after fault
// - Undervoltage mode 0 always faults
// - Mode 1: warn disabled, fault enabled
// - Torque-off missing at enable raises fault
// - Hardware disable removes power at once
// - Immediate software disable removes power now
// - Mode 2 decelerates before disabling
// - Stop input: decelerate, disable, brake
// - Faults use their configured shutdown class
// - Stops beat starts; category 0 wins
// - Category 1 keeps power until done
// - Emergency stop overrides; clearing never restarts
// - Torque-off removal coasts and faults
`timescale 1ns/100ps
`default_nettype none
module stop_brake_seq #(
   parameter int VEL_W = 16,
   parameter logic [31:0] STOP_TIMEOUT_DEFAULT = stop_seq_pkg::STOP_TIMEOUT_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Enables and stop requests
   input wire logic hw_enable,
   input wire logic safe_torque_off_input,
   input wire logic stop_input,
   input wire logic estop,
   input wire logic undervoltage,
   input wire logic ext_fault,
   input wire logic [VEL_W-1:0] velocity,
   // Power stage and brake
   output logic power_enable,
   output logic decel_cmd,
   output logic dyn_brake,
   output logic brake_engage,
   output logic drive_active
);
   // Sequencer states, Gray coded along run -> decel -> off
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RUN = 3'b001,
      ST_DECEL = 3'b011,
      ST_OFF = 3'b010,
      ST_DYNB = 3'b110
   } seq_t;

   // Whole state of the sequencer, registered in one place
   typedef struct packed {
      seq_t st;
      logic software_enable;        // Software enable bit
      logic [31:0] cfg;       // Configuration register
      logic [VEL_W-1:0] vth;  // Stop velocity threshold
      logic [31:0] tmo;       // Stop timeout in cycles
      logic [3:0] flt;        // Sticky fault and warning bits
      logic brake;            // Holding brake command
      logic hw_en_d;          // Previous hardware enable
      logic estop_latched;    // Emergency stop seen, blocks restart
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic power;
      logic decel;
      logic dynb;
      logic active;
   } state_t;
   state_t cur_ff, nxt_ff;

   logic stop_done;
   logic stopping;

   // Unmapped offsets answer with an error and no side effect
   // Register address decode
   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a == stop_seq_pkg::CTRL_OFFS) || (a == stop_seq_pkg::CONFIG_OFFS) ||
         (a == stop_seq_pkg::VTHRESH_OFFS) || (a == stop_seq_pkg::TIMEOUT_OFFS) ||
         (a == stop_seq_pkg::STATUS_OFFS) || (a == stop_seq_pkg::FAULT_OFFS);
   endfunction

   // Stop timer runs while power is off or decelerating without brake
   assign stopping = (cur_ff.st == ST_DECEL) || (cur_ff.st == ST_DYNB) ||
      ((cur_ff.st == ST_OFF) && !cur_ff.brake);

   // Limitation: the timeout counts clock cycles, so software scales it to the clock
   stop_timer #(
      .VEL_W(VEL_W)
   ) u_timer (
      .clock(clock),
      .rst_n(rst_n),
      .running(stopping),
      .velocity(velocity),
      .threshold(cur_ff.vth),
      .timeout_cycles(cur_ff.tmo),
      .done(stop_done)
   );

   // Fault class selectors, declared ahead of the sequencer that decodes them
   localparam logic [1:0] FCLASS_DYNBRAKE_SEL = stop_seq_pkg::FCLASS_DYNBRAKE;
   localparam logic [1:0] FCLASS_CONTROLLED_SEL = stop_seq_pkg::FCLASS_CONTROLLED;

   // Next state: bus, faults and sequencing
   always_comb begin
      logic [1:0] dismode;
      logic [1:0] fclass;
      logic brakeimm;
      logic uvmode;
      logic access;
      logic wr;
      logic new_fault;
      logic cat0;
      logic want_run;
      nxt_ff = cur_ff;
      // Everything holds unless a branch below moves it
      cat0 = 1'b0;
      want_run = 1'b0;
      dismode = cur_ff.cfg[stop_seq_pkg::CFG_DISMODE_LSB +: 2];
      fclass = cur_ff.cfg[stop_seq_pkg::CFG_FCLASS_LSB +: 2];
      brakeimm = cur_ff.cfg[stop_seq_pkg::CFG_BRAKEIMM];
      uvmode = cur_ff.cfg[stop_seq_pkg::CFG_UVMODE];
      access = psel && penable && !cur_ff.ready;
      wr = access && pwrite;
      new_fault = 1'b0;
      // One wait state: ready is a registered pulse, so a held access is taken once
      nxt_ff.ready = access;
      nxt_ff.err = access && !known_addr(paddr);
      // Delayed enable finds the rising edge for the torque-off check
      nxt_ff.hw_en_d = hw_enable;
      // Register writes; fault clear acts before new events so sets win
      if (wr) begin
         unique case (paddr)
            stop_seq_pkg::CTRL_OFFS: begin
               nxt_ff.software_enable = pwdata[stop_seq_pkg::CTRL_SOFTWARE_ENABLE];
               if (pwdata[stop_seq_pkg::CTRL_FAULT_CLEAR]) begin
                  nxt_ff.flt = 4'h0;
               end
            end
            stop_seq_pkg::CONFIG_OFFS: nxt_ff.cfg = {24'h00_0000, pwdata[7:0]};
            stop_seq_pkg::VTHRESH_OFFS: nxt_ff.vth = pwdata[VEL_W-1:0];
            stop_seq_pkg::TIMEOUT_OFFS: nxt_ff.tmo = pwdata;
            default: ;
         endcase
      end
      // Read data stands for one cycle with pready and is zero otherwise
      // Read data
      nxt_ff.rdata = 32'h0000_0000;
      if (access && !pwrite) begin
         unique case (paddr)
            stop_seq_pkg::CTRL_OFFS: nxt_ff.rdata = {31'h0, cur_ff.software_enable};
            stop_seq_pkg::CONFIG_OFFS: nxt_ff.rdata = cur_ff.cfg;
            stop_seq_pkg::VTHRESH_OFFS: nxt_ff.rdata = 32'(cur_ff.vth);
            stop_seq_pkg::TIMEOUT_OFFS: nxt_ff.rdata = cur_ff.tmo;
            stop_seq_pkg::STATUS_OFFS: nxt_ff.rdata = {24'h00_0000, cur_ff.estop_latched,
               cur_ff.brake, cur_ff.active, cur_ff.st, 2'h0} | 32'(cur_ff.dynb);
            stop_seq_pkg::FAULT_OFFS: nxt_ff.rdata = {28'h000_0000, cur_ff.flt};
            default: ;
         endcase
      end
      // Mode 1 only faults once the drive is, or is being, enabled
      // Undervoltage policy
      if (undervoltage) begin
         if (!uvmode) begin
            nxt_ff.flt[stop_seq_pkg::FLT_UNDERVOLT] = 1'b1;
            new_fault = 1'b1;
         end else if (cur_ff.active || (hw_enable && cur_ff.software_enable)) begin
            nxt_ff.flt[stop_seq_pkg::FLT_UNDERVOLT] = 1'b1;
            new_fault = 1'b1;
         end else begin
            nxt_ff.flt[stop_seq_pkg::WRN_UNDERVOLT] = 1'b1;
         end
      end
      // Torque-off missing at enable edge or lost while running
      if ((hw_enable && !cur_ff.hw_en_d && !safe_torque_off_input) ||
         (cur_ff.power && !safe_torque_off_input)) begin
         nxt_ff.flt[stop_seq_pkg::FLT_TORQUE_OFF] = 1'b1;
         new_fault = 1'b1;
      end
      // External fault is a one-cycle event; the sticky bit remembers it
      if (ext_fault) begin
         nxt_ff.flt[stop_seq_pkg::FLT_EXTERNAL] = 1'b1;
         new_fault = 1'b1;
      end
      // Trade-off: the latch costs a software step, but no release restarts the axis
      // Emergency stop latches until software drops its enable
      if (estop) begin
         nxt_ff.estop_latched = 1'b1;
      end else if (!cur_ff.software_enable) begin
         nxt_ff.estop_latched = 1'b0;
      end
      // Uncontrolled stop sources take priority over controlled ones
      cat0 = estop || !hw_enable || !safe_torque_off_input;
      want_run = hw_enable && cur_ff.software_enable && safe_torque_off_input && !estop &&
         !cur_ff.estop_latched && (cur_ff.flt[2:0] == 3'h0) && !stop_input && !undervoltage;
      // A fault raised in this cycle blocks a start in the same cycle
      // Sequencer
      unique case (cur_ff.st)
         // Standing states: brake once the stop completes, start when allowed
         ST_IDLE, ST_OFF: begin
            if (stop_done) begin
               nxt_ff.brake = 1'b1;
            end
            if (want_run && !cat0 && !new_fault) begin
               nxt_ff.st = ST_RUN;
            end else if (cur_ff.st == ST_IDLE) begin
               nxt_ff.st = ST_IDLE;
            end
         end
         // Moving states: uncontrolled stops first, then faults, then requests
         ST_RUN, ST_DECEL, ST_DYNB: begin
            if (cat0) begin
               nxt_ff.st = ST_OFF;
               nxt_ff.brake = nxt_ff.brake | brakeimm;
            end else if (new_fault) begin
               unique case (fclass)
                  FCLASS_DYNBRAKE_SEL: nxt_ff.st = ST_DYNB;
                  FCLASS_CONTROLLED_SEL: nxt_ff.st = ST_DECEL;
                  default: nxt_ff.st = ST_OFF;
               endcase
               if (brakeimm) begin
                  nxt_ff.st = ST_OFF;
                  nxt_ff.brake = 1'b1;
               end
            end else if (cur_ff.st == ST_RUN) begin
               if (stop_input) begin
                  nxt_ff.st = ST_DECEL;
               end else if (!cur_ff.software_enable) begin
                  if (dismode == stop_seq_pkg::DISMODE_CONTROLLED) begin
                     nxt_ff.st = ST_DECEL;
                  end else begin
                     nxt_ff.st = ST_OFF;
                  end
               end
            end else if (stop_done) begin
               // Power removed only once deceleration completes
               nxt_ff.st = ST_OFF;
               nxt_ff.brake = 1'b1;
            end
         end
         // Illegal code: fall to the safe powered-off state
         default: nxt_ff.st = ST_OFF;
      endcase
      // Running releases the brake; other states keep it as it is, except ST_IDLE, which sets it below
      if (nxt_ff.st == ST_RUN) begin
         nxt_ff.brake = 1'b0;
      end
      // Registered outputs follow the next state so they change together
      nxt_ff.power = (nxt_ff.st == ST_RUN) || (nxt_ff.st == ST_DECEL);
      nxt_ff.decel = (nxt_ff.st == ST_DECEL);
      nxt_ff.dynb = (nxt_ff.st == ST_DYNB);
      nxt_ff.active = (nxt_ff.st == ST_RUN);
      // Stops that end in a standing state reach the brake through the timer
      // Losing the active indication sets the brake here only if the next state is not ST_DECEL, ST_DYNB or ST_OFF
      if (cur_ff.active && !nxt_ff.active && nxt_ff.st != ST_DECEL && nxt_ff.st != ST_DYNB &&
         nxt_ff.st != ST_OFF) begin
         nxt_ff.brake = 1'b1;
      end
      // Idle always holds the brake
      if (nxt_ff.st == ST_IDLE) begin
         nxt_ff.brake = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         // Brake engaged and power off is the only safe state out of reset
         cur_ff <= '{st: ST_IDLE, software_enable: 1'b0, cfg: stop_seq_pkg::CONFIG_RESET,
            vth: stop_seq_pkg::VTHRESH_RESET[VEL_W-1:0], tmo: STOP_TIMEOUT_DEFAULT,
            flt: 4'h0, brake: 1'b1, hw_en_d: 1'b0, estop_latched: 1'b0,
            rdata: 32'h0000_0000, ready: 1'b0, err: 1'b0, power: 1'b0, decel: 1'b0,
            dynb: 1'b0, active: 1'b0};
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // Brake output is a level: the far side holds the brake while it is high
   // Outputs straight from flip-flops
   assign prdata = cur_ff.rdata;
   assign pready = cur_ff.ready;
   assign pslverr = cur_ff.err;
   assign power_enable = cur_ff.power;
   assign decel_cmd = cur_ff.decel;
   assign dyn_brake = cur_ff.dynb;
   assign brake_engage = cur_ff.brake;
   assign drive_active = cur_ff.active;
endmodule // stop_brake_seq
`default_nettype wire

/* File: verification/motor_model.sv */
/*
  Motor model on the far side of the power stage: gives back a speed.
  Assumes power_enable and the brake commands are registered levels.
*/
`timescale 1ns/100ps
`default_nettype none
module motor_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Power stage commands
   input wire logic power_enable,
   input wire logic decel_cmd,
   input wire logic dyn_brake,
   input wire logic [15:0] run_speed,
   // Measured speed
   output logic [15:0] velocity
);
   // Braking is fast, so the threshold wins; coasting is slow, so the timeout wins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         velocity <= 16'h0000;
      end else if (power_enable && !decel_cmd) begin
         velocity <= run_speed;
      end else if (decel_cmd || dyn_brake) begin
         velocity <= (velocity > 16'h0040) ? velocity - 16'h0040 : 16'h0000;
      end else begin
         velocity <= (velocity > 16'h0002) ? velocity - 16'h0002 : 16'h0000;
      end
   end
endmodule // motor_model
`default_nettype wire

/* File: verification/stop_brake_seq_properties.sv */
/*
  Checker of power stage and brake outputs of the sequencer.
  Assumes a stop timeout of a few tens of cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module stop_brake_seq_properties (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Requests
   input wire logic hw_enable,
   input wire logic safe_torque_off_input,
   input wire logic stop_input,
   input wire logic estop,
   // Outputs
   input wire logic power_enable,
   input wire logic decel_cmd,
   input wire logic brake_engage,
   input wire logic drive_active
);
   // One domain only
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_inactive_brakes: assert property ($fell(drive_active) |-> ##[0:40] brake_engage)
      else $error("brake late after drive inactive");
   a_brake_after_off: assert property (power_enable |-> !brake_engage)
      else $error("brake on while powered");
   a_hw_disable_cut: assert property (!hw_enable |=> !power_enable)
      else $error("power kept without hw enable");
   a_sto_coasts: assert property (!safe_torque_off_input |=> !power_enable)
      else $error("power kept without torque-off input");
   a_estop_cuts: assert property (estop |=> !power_enable)
      else $error("power kept during estop");
   a_estop_no_restart: assert property ($fell(estop) |-> !power_enable [*4])
      else $error("restart on estop release");
   a_cat0_wins: assert property (estop && stop_input |=> !decel_cmd && !power_enable)
      else $error("controlled stop beat estop");
   a_stop_beats_start: assert property (stop_input && !power_enable |=> !power_enable)
      else $error("start during stop");
   a_decel_powered: assert property (decel_cmd |-> power_enable)
      else $error("decel without power");
endmodule // stop_brake_seq_properties
bind stop_brake_seq stop_brake_seq_properties stop_brake_seq_properties_inst (.clock, .rst_n,
   .hw_enable, .safe_torque_off_input, .stop_input, .estop, .power_enable, .decel_cmd,
   .brake_engage, .drive_active);
`default_nettype wire

/* File: verification/tb.sv */
/*
  Testbench of the stop and brake sequencer, APB master and motor model.
  Assumes timeout shortened to 20 cycles by parameter.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, (e), (g)); end end
module tb;
   // Bus and requests
   logic clock = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic pready, pslverr, hw_enable = 1'h0, safe_torque_off_input = 1'h0, stop_input = 1'h0;
   logic estop = 1'h0, undervoltage = 1'h0, ext_fault = 1'h0;
   logic [15:0] velocity, run_speed = 16'h0000;
   logic power_enable, decel_cmd, dyn_brake, brake_engage, drive_active;
   // Expected bus answers: {pslverr, prdata} then mask
   logic [65:0] notes[$];
   logic [65:0] note;
   int errors = 0, num_checks = 0, cycles = 0;
   always #12.5 clock = ~clock;
   stop_brake_seq #(.STOP_TIMEOUT_DEFAULT(32'h0000_0014)) stop_brake_seq_inst (.clock, .rst_n,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hw_enable,
      .safe_torque_off_input, .stop_input, .estop, .undervoltage, .ext_fault, .velocity,
      .power_enable, .decel_cmd, .dyn_brake, .brake_engage, .drive_active);
   motor_model motor_model_inst (.clock, .rst_n, .power_enable, .decel_cmd, .dyn_brake,
      .run_speed, .velocity);
   task automatic end_of_test();
      if (errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard, far above the expected run
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end
   // Oldest note against each bus answer
   always @(posedge clock) begin
      if (pready === 1'h1) begin
         note = notes.pop_front();
         `CHK("apb", note[65:33], {pslverr, prdata} & note[32:0])
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e, input logic [32:0] m);
      notes.push_back({e, m});
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      @(posedge clock);
      while (pready !== 1'h1) @(posedge clock);
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d, 33'h0_0000_0000, 33'h1_0000_0000);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      apb(1'h0, a, 32'h0000_0000, e, m);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Reset with all requests idle and a fresh random speed
   task automatic do_reset();
      rst_n <= 1'h0;
      hw_enable <= 1'h0;
      safe_torque_off_input <= 1'h1;
      stop_input <= 1'h0;
      estop <= 1'h0;
      undervoltage <= 1'h0;
      run_speed <= 16'(600 + $urandom % 400);
      idle(10);
      rst_n <= 1'h1;
      idle(1);
   endtask
   task automatic start(input logic [31:0] cfg);
      do_reset();
      wr(stop_seq_pkg::CONFIG_OFFS, cfg);
      hw_enable <= 1'h1;
      wr(stop_seq_pkg::CTRL_OFFS, 32'h0000_0001);
      idle(3);
   endtask
   task automatic wait_brake();
      for (int i = 0; i < 100 && brake_engage !== 1'h1; i++) @(posedge clock);
      `CHK("brake_engage", 1'h1, brake_engage)
   endtask
   initial begin
      void'($urandom(98));
      do_reset();
      `CHK("brake_engage", 1'h1, brake_engage)
      rd(stop_seq_pkg::CONFIG_OFFS, 33'h0_0000_0008, 33'h0_FFFF_FFFF);
      rd(stop_seq_pkg::VTHRESH_OFFS, 33'h0_0000_0064, 33'h0_FFFF_FFFF);
      rd(stop_seq_pkg::TIMEOUT_OFFS, 33'h0_0000_0014, 33'h0_FFFF_FFFF);
      wr(stop_seq_pkg::VTHRESH_OFFS, 32'h0000_0123);
      rd(stop_seq_pkg::VTHRESH_OFFS, 33'h0_0000_0123, 33'h0_FFFF_FFFF);
      rd(8'h20, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
      // Hardware disable: immediate cut, then brake
      start(32'h0000_0008);
      `CHK("drive_active", 1'h1, drive_active)
      hw_enable <= 1'h0;
      idle(3);
      `CHK("power_enable", 1'h0, power_enable)
      wait_brake();
      // Controlled software disable, set as mode 2 for stop categories
      start(32'h0000_000A);
      wr(stop_seq_pkg::CTRL_OFFS, 32'h0000_0000);
      idle(2);
      `CHK("decel_cmd", 1'h1, decel_cmd)
      `CHK("power_enable", 1'h1, power_enable)
      wait_brake();
      `CHK("power_enable", 1'h0, power_enable)
      // Immediate software disable
      start(32'h0000_0008);
      wr(stop_seq_pkg::CTRL_OFFS, 32'h0000_0000);
      idle(2);
      `CHK("power_enable", 1'h0, power_enable)
      wait_brake();
      // Stop input
      start(32'h0000_0008);
      stop_input <= 1'h1;
      idle(3);
      `CHK("decel_cmd", 1'h1, decel_cmd)
      wait_brake();
      // Every fault shutdown class
      for (int c = 0; c < 3; c++) begin
         start(32'h0000_0008 | (32'(c) << 4));
         ext_fault <= 1'h1;
         idle(1);
         ext_fault <= 1'h0;
         idle(3);
         `CHK("dyn_brake", 1'(c == 1), dyn_brake)
         `CHK("decel_cmd", 1'(c == 2), decel_cmd)
         `CHK("power_enable", 1'(c == 2), power_enable)
         wait_brake();
         rd(stop_seq_pkg::FAULT_OFFS, 33'h0_0000_0004, 33'h0_0000_0004);
      end
      // Brake at once on hardware disable while still fast
      start(32'h0000_000C);
      hw_enable <= 1'h0;
      idle(3);
      `CHK("brake_engage", 1'h1, brake_engage)
      // Brake at once on a fault, even with a controlled stop class
      start(32'h0000_002C);
      ext_fault <= 1'h1;
      idle(1);
      ext_fault <= 1'h0;
      idle(3);
      `CHK("brake_engage", 1'h1, brake_engage)
      `CHK("decel_cmd", 1'h0, decel_cmd)
      // Estop with a concurrent controlled stop, then release
      start(32'h0000_000A);
      estop <= 1'h1;
      stop_input <= 1'h1;
      idle(3);
      `CHK("decel_cmd", 1'h0, decel_cmd)
      estop <= 1'h0;
      stop_input <= 1'h0;
      idle(6);
      `CHK("power_enable", 1'h0, power_enable)
      // Torque-off input missing at enable, then lost while running
      do_reset();
      safe_torque_off_input <= 1'h0;
      hw_enable <= 1'h1;
      idle(3);
      rd(stop_seq_pkg::FAULT_OFFS, 33'h0_0000_0002, 33'h0_0000_0002);
      start(32'h0000_0008);
      safe_torque_off_input <= 1'h0;
      idle(3);
      `CHK("decel_cmd", 1'h0, decel_cmd)
      rd(stop_seq_pkg::FAULT_OFFS, 33'h0_0000_0002, 33'h0_0000_0002);
      // Undervoltage in both modes
      start(32'h0000_0000);
      wr(stop_seq_pkg::CTRL_OFFS, 32'h0000_0000);
      undervoltage <= 1'h1;
      idle(3);
      rd(stop_seq_pkg::FAULT_OFFS, 33'h0_0000_0001, 33'h0_0000_0001);
      do_reset();
      undervoltage <= 1'h1;
      idle(3);
      rd(stop_seq_pkg::FAULT_OFFS, 33'h0_0000_0008, 33'h0_0000_0009);
      hw_enable <= 1'h1;
      wr(stop_seq_pkg::CTRL_OFFS, 32'h0000_0001);
      rd(stop_seq_pkg::FAULT_OFFS, 33'h0_0000_0001, 33'h0_0000_0001);
      start(32'h0000_0008);
      undervoltage <= 1'h1;
      idle(3);
      rd(stop_seq_pkg::FAULT_OFFS, 33'h0_0000_0001, 33'h0_0000_0001);
      // Fault clear empties the sticky bits once the condition is gone
      undervoltage <= 1'h0;
      wr(stop_seq_pkg::CTRL_OFFS, 32'h0000_0002);
      rd(stop_seq_pkg::FAULT_OFFS, 33'h0_0000_0000, 33'h0_0000_000F);
      end_of_test();
   end
endmodule // tb
`default_nettype wire
